// ===== core/gtw_timers.sv
// General timers: event capture timer, wake-up timer and watchdog timer.
// Functional notes
// [R01] Capture enable bit 17 gates event capture.
// [R02] Five-bit selector picks event N plus two.
// [R03] First timer source: core, crystal, pin A, pin B.
// [R04] Bit 8 selects up count, down default.
// [R05] Bit 7 enables counting, stopped by default.
// [R06] Bit 6 selects periodic, free-running default.
// [R07] Format: binary, or time wrapping 23/255 hours.
// [R08] Prescale field divides source by two-power.
// [R09] Any clear write drops first timer interrupt.
// [R10] Event copies first counter into capture register.
// [R11] Wake-up timer: three sources, four prescales, formats.
// [R12] Wake-up timer runs while core clock stops.
// [R13] Wake-up count read-only, live, resets all ones.
// [R14] Third timer up, enable, periodic bits 8..6.
// [R15] Bit 5 enables watchdog operation.
// [R16] Third prescale 1, 16, 256; code 11 is 1.
// [R17] Bit 1 turns watchdog expiry into interrupt.
// [R18] Clear write drops interrupt or restarts timeout.
// [R19] Secure clear needs expected value each write.
// [R20] Expected values from x8+x6+x5+x+1 shift register.
// [R21] Seed before watchdog; match steps on reload.
// [R22] Mismatching secure write resets chip at once.
// [R23] Zero seed always forces immediate reset.
// [R24] Periodic expiry reloads and interrupts; free wraps.
// [R25] Watchdog expiry without interrupt option resets chip.
`include "gtw_map.svh"

module gtw_timers (
   input wire logic clk_sys_i,                 // System clock, 250 MHz.
   input wire logic rst_i,                     // Synchronous reset.
   input wire logic [31:0] paddr_i,            // APB address.
   input wire logic psel_i,                    // APB select.
   input wire logic penable_i,                 // APB enable.
   input wire logic pwrite_i,                  // APB write.
   input wire gtw_pkg::gtw_word_t pwdata_i,    // APB write data.
   output gtw_pkg::gtw_word_t prdata_o,        // APB read data.
   output logic pready_o,                      // APB ready.
   output logic pslverr_o,                     // APB error.
   input wire logic core_run_i,                // Core clock running.
   input wire logic xtal_tick_i,               // Crystal tick pulse.
   input wire logic osc_tick_i,                // Internal oscillator tick.
   input wire logic pin_a_i,                   // Count pin A.
   input wire logic pin_b_i,                   // Count pin B.
   input wire logic [33:0] events_i,           // System event pulses.
   output logic t1_irq_o,                      // First timer interrupt.
   output logic t2_irq_o,                      // Wake-up timer interrupt.
   output logic t3_irq_o,                      // Third timer interrupt.
   output logic wd_reset_o                     // Chip reset request.
);
   import gtw_pkg::*;

   localparam int NT = 3;

   gtw_word_t cfg_reg [NT];
   gtw_word_t load_reg [NT];
   gtw_word_t cnt_reg [NT];
   logic [14:0] pre_reg [NT];
   logic irq_reg [NT];
   gtw_word_t cap_reg;
   logic [7:0] lfsr_reg;
   logic wd_rst_reg;
   logic pin_a_reg;
   logic pin_b_reg;
   gtw_word_t prdata_reg;
   gtw_word_t rd_next;
   logic rd_hit;

   logic cfg_up [NT];
   logic cfg_en [NT];
   logic cfg_per [NT];
   logic [1:0] cfg_fmt [NT];
   gtw_shift_t cfg_shift [NT];
   logic src_tick [NT];
   logic cnt_tick [NT];
   logic expire [NT];
   logic wr_load [NT];
   logic wr_cfg [NT];
   logic wr_clr [NT];
   logic force_reload [NT];
   logic set_irq [NT];
   gtw_word_t step_val [NT];

   logic wr_en;
   logic wr_cap;
   logic wd_mode;
   logic wd_irq_opt;
   logic wd_secure;
   logic sec_good;
   logic sec_bad;
   logic [4:0] ev_sel;
   logic [5:0] ev_idx;
   logic ev_hit;
   logic [1:0] t2_src;
   logic [1:0] t2_pre;
   logic [1:0] t3_pre;

   // Steps a counter by one in binary or hours:minutes:seconds:hundredths.
   function automatic gtw_word_t gtw_step(input gtw_word_t v,
                                          input logic up,
                                          input logic [1:0] fmt);
      logic [6:0] c;
      logic [5:0] s;
      logic [5:0] m;
      logic [7:0] h;
      logic [7:0] top;
      c = v[6:0];
      s = v[13:8];
      m = v[21:16];
      h = v[31:24];
      top = fmt[0] ? `GTW_HOUR255_MAX : `GTW_HOUR23_MAX;
      if (!fmt[1]) begin
         gtw_step = up ? v + 32'h1 : v - 32'h1;
      end else begin
         if (up) begin
            if (c != `GTW_HUND_MAX) c = c + 7'h1;
            else begin
               c = 7'h0;
               if (s != `GTW_MINSEC_MAX) s = s + 6'h1;
               else begin
                  s = 6'h0;
                  if (m != `GTW_MINSEC_MAX) m = m + 6'h1;
                  else begin
                     m = 6'h0;
                     h = (h == top) ? 8'h0 : h + 8'h1;
                  end
               end
            end
         end else begin
            if (c != 7'h0) c = c - 7'h1;
            else begin
               c = `GTW_HUND_MAX;
               if (s != 6'h0) s = s - 6'h1;
               else begin
                  s = `GTW_MINSEC_MAX;
                  if (m != 6'h0) m = m - 6'h1;
                  else begin
                     m = `GTW_MINSEC_MAX;
                     h = (h == 8'h0) ? top : h - 8'h1;
                  end
               end
            end
         end
         gtw_step = {h, 2'b00, m, 2'b00, s, 1'b0, c};
      end
   endfunction : gtw_step

   // Terminal count: zero going down, top of the range going up.
   function automatic logic gtw_last(input gtw_word_t v, input logic up,
                                     input logic [1:0] fmt);
      gtw_word_t top;
      top = {fmt[0] ? `GTW_HOUR255_MAX : `GTW_HOUR23_MAX, 2'b00,
             `GTW_MINSEC_MAX, 2'b00, `GTW_MINSEC_MAX, 1'b0, `GTW_HUND_MAX};
      if (!up) gtw_last = (v == 32'h0);
      else if (!fmt[1]) gtw_last = (v == 32'hFFFF_FFFF);
      else gtw_last = (v == top);
   endfunction : gtw_last

   // Bus access decode; the slave never inserts wait states.
   assign wr_en = psel_i && penable_i && pwrite_i;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !rd_hit;
   assign prdata_o = prdata_reg;

   assign wr_load[0] = wr_en && (paddr_i == `GTW_T1_LOAD_ADDR);
   assign wr_load[1] = wr_en && (paddr_i == `GTW_T2_LOAD_ADDR);
   assign wr_load[2] = wr_en && (paddr_i == `GTW_T3_LOAD_ADDR);
   assign wr_cfg[0] = wr_en && (paddr_i == `GTW_T1_CFG_ADDR);
   assign wr_cfg[1] = wr_en && (paddr_i == `GTW_T2_CFG_ADDR);
   assign wr_cfg[2] = wr_en && (paddr_i == `GTW_T3_CFG_ADDR);
   assign wr_clr[0] = wr_en && (paddr_i == `GTW_T1_CLR_ADDR);
   assign wr_clr[1] = wr_en && (paddr_i == `GTW_T2_CLR_ADDR);
   assign wr_clr[2] = wr_en && (paddr_i == `GTW_T3_CLR_ADDR);
   assign wr_cap = wr_en && (paddr_i == `GTW_T1_CAP_ADDR);

   // Configuration fields of the three timers.
   assign wd_mode = cfg_reg[2][`GTW_WD_BIT];                         // R15
   assign wd_irq_opt = cfg_reg[2][`GTW_WDIRQ_BIT];
   assign wd_secure = wd_mode && cfg_reg[2][`GTW_SEC_BIT];
   assign t2_src = cfg_reg[1][`GTW_T2SRC_MSB:`GTW_T2SRC_LSB];
   assign t2_pre = cfg_reg[1][`GTW_T2PRE_MSB:`GTW_T2PRE_LSB];
   assign t3_pre = cfg_reg[2][`GTW_T3PRE_MSB:`GTW_T3PRE_LSB];

   always_comb begin
      for (int i = 0; i < NT; i++) begin
         cfg_up[i] = cfg_reg[i][`GTW_UP_BIT];                         // R04 R14
         cfg_en[i] = cfg_reg[i][`GTW_EN_BIT];                         // R05 R14
         cfg_per[i] = cfg_reg[i][`GTW_PER_BIT];                       // R06 R14
      end
      cfg_fmt[0] = cfg_reg[0][`GTW_FMT_MSB:`GTW_FMT_LSB];             // R07
      cfg_fmt[1] = cfg_reg[1][`GTW_FMT_MSB:`GTW_FMT_LSB];             // R11
      cfg_fmt[2] = 2'b00;
      cfg_shift[0] = cfg_reg[0][`GTW_T1PRE_MSB:`GTW_T1PRE_LSB];       // R08
      case (t2_pre)                                                   // R11
         2'b00: cfg_shift[1] = 4'h0;
         2'b01: cfg_shift[1] = 4'h4;
         2'b10: cfg_shift[1] = 4'h8;
         default: cfg_shift[1] = 4'hF;
      endcase
      case (t3_pre)                                                   // R16
         2'b01: cfg_shift[2] = 4'h4;
         2'b10: cfg_shift[2] = 4'h8;
         default: cfg_shift[2] = 4'h0;
      endcase
      // The watchdog always counts down and reloads on expiry.
      if (wd_mode) begin
         cfg_up[2] = 1'b0;
         cfg_per[2] = 1'b1;
      end
   end

   // Source ticks; pins count on rising edges.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         pin_a_reg <= 1'b0;
         pin_b_reg <= 1'b0;
      end else begin
         pin_a_reg <= pin_a_i;
         pin_b_reg <= pin_b_i;
      end
   end

   always_comb begin
      case (cfg_reg[0][`GTW_T1SRC_MSB:`GTW_T1SRC_LSB])               // R03
         3'b000: src_tick[0] = core_run_i;
         3'b001: src_tick[0] = xtal_tick_i;
         3'b010: src_tick[0] = pin_a_i && !pin_a_reg;
         3'b011: src_tick[0] = pin_b_i && !pin_b_reg;
         default: src_tick[0] = 1'b0;
      endcase
      // The wake-up counter lives in the always-on clock domain, so a
      // stopped core clock only removes the core source, not the count.
      case (t2_src)                                                   // R11 R12
         2'b00: src_tick[1] = xtal_tick_i;
         2'b01: src_tick[1] = core_run_i;
         2'b10: src_tick[1] = osc_tick_i;
         default: src_tick[1] = 1'b0;
      endcase
      src_tick[2] = core_run_i;
   end

   // Watchdog clear writes and the secure sequence check.
   assign sec_good = wd_secure && wr_clr[2] && (lfsr_reg != 8'h00)
                     && (pwdata_i[7:0] == lfsr_reg);                  // R19
   assign sec_bad = wd_secure && wr_clr[2] && !sec_good;             // R22 R23
   assign force_reload[0] = 1'b0;
   assign force_reload[1] = 1'b0;
   assign force_reload[2] = wd_mode && wr_clr[2] && !sec_bad;        // R18

   genvar g;
   generate
      for (g = 0; g < NT; g++) begin : g_timer
         logic [14:0] pre_mask;
         assign pre_mask = 15'((32'h1 << cfg_shift[g]) - 32'h1);
         assign cnt_tick[g] = cfg_en[g] && src_tick[g]
                              && ((pre_reg[g] & pre_mask) == pre_mask);
         assign expire[g] = cnt_tick[g]
                            && gtw_last(cnt_reg[g], cfg_up[g], cfg_fmt[g]);
         assign step_val[g] = gtw_step(cnt_reg[g], cfg_up[g], cfg_fmt[g]);

         always_ff @(posedge clk_sys_i) begin
            if (rst_i || wr_cfg[g]) begin
               pre_reg[g] <= 15'h0;
            end else if (cfg_en[g] && src_tick[g]) begin              // R08
               pre_reg[g] <= pre_reg[g] + 15'h1;
            end
         end

         always_ff @(posedge clk_sys_i) begin
            if (rst_i) begin
               cnt_reg[g] <= (g == 1) ? `GTW_T2_COUNT_RESET           // R13
                                      : `GTW_COUNT_RESET;
            end else if (wr_load[g] || force_reload[g]) begin
               cnt_reg[g] <= wr_load[g] ? pwdata_i : load_reg[g];
            end else if (expire[g] && cfg_per[g]) begin
               cnt_reg[g] <= load_reg[g];                             // R24
            end else if (cnt_tick[g]) begin
               cnt_reg[g] <= step_val[g];                             // R05 R24
            end
         end

         always_ff @(posedge clk_sys_i) begin
            if (rst_i) begin
               load_reg[g] <= `GTW_LOAD_RESET;
            end else if (wr_load[g]) begin
               load_reg[g] <= pwdata_i;
            end
         end

         // An expiry that raises the flag in the clearing cycle keeps it set.
         always_ff @(posedge clk_sys_i) begin
            if (rst_i) begin
               irq_reg[g] <= 1'b0;
            end else if (set_irq[g]) begin
               irq_reg[g] <= 1'b1;
            end else if (wr_clr[g]) begin
               irq_reg[g] <= 1'b0;                                    // R09 R18
            end
         end
      end
   endgenerate

   assign set_irq[0] = expire[0] && cfg_per[0];                      // R24
   assign set_irq[1] = expire[1] && cfg_per[1];
   assign set_irq[2] = expire[2] && (cfg_per[2] && (!wd_mode || wd_irq_opt));

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cfg_reg[0] <= `GTW_CFG_RESET;
         cfg_reg[1] <= `GTW_CFG_RESET;
         cfg_reg[2] <= `GTW_CFG_RESET;
      end else begin
         if (wr_cfg[0]) cfg_reg[0] <= pwdata_i & `GTW_T1_CFG_MASK;
         if (wr_cfg[1]) cfg_reg[1] <= pwdata_i & `GTW_T2_CFG_MASK;
         if (wr_cfg[2]) cfg_reg[2] <= pwdata_i & `GTW_T3_CFG_MASK;
      end
   end

   // Event capture of the first timer.
   assign ev_sel = cfg_reg[0][`GTW_EVSEL_MSB:`GTW_EVSEL_LSB];
   assign ev_idx = {1'b0, ev_sel} + `GTW_EV_OFFSET;                   // R02
   assign ev_hit = cfg_reg[0][`GTW_CAPEN_BIT] && events_i[ev_idx];    // R01

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cap_reg <= 32'h0;
      end else if (ev_hit) begin
         cap_reg <= cnt_reg[0];                                       // R10
      end else if (wr_cap) begin
         cap_reg <= pwdata_i;
      end
   end

   // Secure clear sequence; a seed is taken while not in watchdog mode.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         lfsr_reg <= `GTW_LFSR_RESET;
      end else if (wr_clr[2] && !wd_mode) begin
         lfsr_reg <= pwdata_i[7:0];                                   // R21
      end else if (sec_good) begin
         lfsr_reg <= {lfsr_reg[6:0], 1'b0}
                     ^ (lfsr_reg[7] ? `GTW_LFSR_POLY : 8'h00);        // R20 R21
      end
   end

   // The reset request stays until the chip reset takes it away.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         wd_rst_reg <= 1'b0;
      end else if (sec_bad || (expire[2] && wd_mode && !wd_irq_opt)) begin
         wd_rst_reg <= 1'b1;                                          // R17 R22 R25
      end
   end

   assign t1_irq_o = irq_reg[0];
   assign t2_irq_o = irq_reg[1];
   assign t3_irq_o = irq_reg[2];
   assign wd_reset_o = wd_rst_reg;

   // Read mux; data is registered in the setup cycle.
   always_comb begin
      rd_hit = 1'b1;
      case (paddr_i)
         `GTW_T1_LOAD_ADDR: rd_next = load_reg[0];
         `GTW_T1_COUNT_ADDR: rd_next = cnt_reg[0];
         `GTW_T1_CFG_ADDR: rd_next = cfg_reg[0];
         `GTW_T1_CAP_ADDR: rd_next = cap_reg;
         `GTW_T2_LOAD_ADDR: rd_next = load_reg[1];
         `GTW_T2_COUNT_ADDR: rd_next = cnt_reg[1];
         `GTW_T2_CFG_ADDR: rd_next = cfg_reg[1];
         `GTW_T3_LOAD_ADDR: rd_next = load_reg[2];
         `GTW_T3_COUNT_ADDR: rd_next = cnt_reg[2];
         `GTW_T3_CFG_ADDR: rd_next = cfg_reg[2];
         `GTW_STATUS_ADDR: rd_next = {28'h0, wd_rst_reg, irq_reg[2],
                                      irq_reg[1], irq_reg[0]};
         `GTW_T1_CLR_ADDR, `GTW_T2_CLR_ADDR, `GTW_T3_CLR_ADDR:
            rd_next = 32'h0;
         default: begin
            rd_next = 32'h0;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         prdata_reg <= 32'h0;
      end else if (psel_i && !penable_i) begin
         prdata_reg <= pwrite_i ? 32'h0 : rd_next;
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   sequence s_bad_write;
      sec_bad;
   endsequence
   sequence s_reset_held;
      wd_reset_o [*3];
   endsequence

   property p_t1_clear;
      wr_clr[0] && !set_irq[0] |=> !t1_irq_o;
   endproperty
   a_t1_clear: assert property (p_t1_clear) // R09
      else $error("first timer interrupt not cleared");

   property p_capture;
      ev_hit |=> cap_reg == $past(cnt_reg[0]);
   endproperty
   a_capture: assert property (p_capture) // R10
      else $error("capture value wrong");

   property p_no_capture;
      !cfg_reg[0][`GTW_CAPEN_BIT] && !wr_cap |=> $stable(cap_reg);
   endproperty
   a_no_capture: assert property (p_no_capture) // R01
      else $error("capture while disabled");

   property p_t1_stopped;
      !cfg_en[0] && !wr_load[0] |=> $stable(cnt_reg[0]);
   endproperty
   a_t1_stopped: assert property (p_t1_stopped) // R05
      else $error("first timer moved while disabled");

   property p_periodic_reload;
      expire[0] && cfg_per[0] && !wr_load[0]
         |=> cnt_reg[0] == $past(load_reg[0]) && t1_irq_o;
   endproperty
   a_periodic_reload: assert property (p_periodic_reload) // R24
      else $error("periodic reload missing");

   property p_wd_expiry;
      expire[2] && wd_mode && !wd_irq_opt |=> s_reset_held;
   endproperty
   a_wd_expiry: assert property (p_wd_expiry) // R25
      else $error("watchdog expiry did not reset");

   property p_secure_bad;
      s_bad_write |=> s_reset_held;
   endproperty
   a_secure_bad: assert property (p_secure_bad) // R22
      else $error("bad secure write did not reset");

   property p_wd_irq;
      expire[2] && wd_mode && wd_irq_opt && !wd_reset_o && !sec_bad
         |=> t3_irq_o && !wd_reset_o;
   endproperty
   a_wd_irq: assert property (p_wd_irq) // R17
      else $error("watchdog interrupt option wrong");

   property p_lfsr_step;
      sec_good |=> lfsr_reg == ({$past(lfsr_reg[6:0]), 1'b0}
         ^ ($past(lfsr_reg[7]) ? `GTW_LFSR_POLY : 8'h00));
   endproperty
   a_lfsr_step: assert property (p_lfsr_step) // R20
      else $error("sequence register did not step");

   property p_t2_reset;
      !rst_i && $past(rst_i) |-> cnt_reg[1] == `GTW_T2_COUNT_RESET;
   endproperty
   a_t2_reset: assert property (disable iff (1'b0) p_t2_reset) // R13
      else $error("wake-up count reset value wrong");

endmodule : gtw_timers

// ===== core/gtw_map.svh
// Address map, field positions, reset values and constants of the timers.
`ifndef GTW_MAP_SVH
`define GTW_MAP_SVH

`define GTW_T1_LOAD_ADDR 32'hFFFF_0320
`define GTW_T1_COUNT_ADDR 32'hFFFF_0324
`define GTW_T1_CFG_ADDR 32'hFFFF_0328
`define GTW_T1_CLR_ADDR 32'hFFFF_032C
`define GTW_T1_CAP_ADDR 32'hFFFF_0330
`define GTW_T2_LOAD_ADDR 32'hFFFF_0340
`define GTW_T2_COUNT_ADDR 32'hFFFF_0344
`define GTW_T2_CFG_ADDR 32'hFFFF_0348
`define GTW_T2_CLR_ADDR 32'hFFFF_034C
`define GTW_T3_LOAD_ADDR 32'hFFFF_0360
`define GTW_T3_COUNT_ADDR 32'hFFFF_0364
`define GTW_T3_CFG_ADDR 32'hFFFF_0368
`define GTW_T3_CLR_ADDR 32'hFFFF_036C
`define GTW_STATUS_ADDR 32'hFFFF_0370

`define GTW_CAPEN_BIT 17
`define GTW_EVSEL_MSB 16
`define GTW_EVSEL_LSB 12
`define GTW_EV_OFFSET 6'h02
`define GTW_T1SRC_MSB 11
`define GTW_T1SRC_LSB 9
`define GTW_UP_BIT 8
`define GTW_EN_BIT 7
`define GTW_PER_BIT 6
`define GTW_FMT_MSB 5
`define GTW_FMT_LSB 4
`define GTW_T1PRE_MSB 3
`define GTW_T1PRE_LSB 0
`define GTW_T2SRC_MSB 10
`define GTW_T2SRC_LSB 9
`define GTW_T2PRE_MSB 3
`define GTW_T2PRE_LSB 2
`define GTW_WD_BIT 5
`define GTW_SEC_BIT 4
`define GTW_T3PRE_MSB 3
`define GTW_T3PRE_LSB 2
`define GTW_WDIRQ_BIT 1

`define GTW_T1_CFG_MASK 32'h0003_FFFF
`define GTW_T2_CFG_MASK 32'h0000_07FC
`define GTW_T3_CFG_MASK 32'h0000_01FE
`define GTW_CFG_RESET 32'h0000_0000
`define GTW_LOAD_RESET 32'h0000_0000
`define GTW_COUNT_RESET 32'h0000_0000
`define GTW_T2_COUNT_RESET 32'hFFFF_FFFF
`define GTW_LFSR_RESET 8'h00
`define GTW_LFSR_POLY 8'h63

`define GTW_HUND_MAX 7'h63
`define GTW_MINSEC_MAX 6'h3B
`define GTW_HOUR23_MAX 8'h17
`define GTW_HOUR255_MAX 8'hFF

`endif

// ===== core/gtw_pkg.sv
// Types shared by the general timers block.
package gtw_pkg;
   typedef logic [31:0] gtw_word_t;
   typedef logic [3:0] gtw_shift_t;
endpackage : gtw_pkg

// ===== test/tb_general_timers_with_watchdog.sv
// Self-checking bench of the general timers block over its APB port.
`include "gtw_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module tb_general_timers_with_watchdog;
   timeunit 1ns;
   timeprecision 1ps;
   import gtw_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic [31:0] paddr_i = '0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   gtw_word_t pwdata_i = '0;
   gtw_word_t prdata_o;
   logic pready_o, pslverr_o, t1_irq_o, t2_irq_o, t3_irq_o, wd_reset_o;
   logic core_run_i = 1'b1;
   logic [3:0] src_p = '0;
   logic [33:0] events_i = '0;
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;
   gtw_word_t q;
   gtw_word_t seq [4] = '{32'hAA, 32'h37, 32'h6E, 32'hDC};

   gtw_timers gtw_timers_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .core_run_i(core_run_i),
      .xtal_tick_i(src_p[0]), .osc_tick_i(src_p[1]), .pin_a_i(src_p[2]),
      .pin_b_i(src_p[3]), .events_i(events_i), .t1_irq_o(t1_irq_o),
      .t2_irq_o(t2_irq_o), .t3_irq_o(t3_irq_o), .wd_reset_o(wd_reset_o));

   initial begin
      forever #2 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run

   // One transfer, then an idle cycle so the next setup never collides.
   task automatic apb(input logic w, input gtw_word_t a, input gtw_word_t d,
                      output logic e);
      int n;
      n = 0;
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      if (n == 50) fail_count++;
      q = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask : apb

   task automatic wr(input gtw_word_t a, input gtw_word_t d);
      logic e;
      apb(1'b1, a, d, e);
   endtask : wr

   task automatic rd(input gtw_word_t a, input gtw_word_t x,
                     input logic xe = 1'b0);
      logic e;
      apb(1'b0, a, '0, e);
      `CHK(q, x)
      `CHK(e, xe)
   endtask : rd

   task automatic pulse(input int b);
      events_i <= 34'h1 << b;
      @(posedge clk_sys_i);
      events_i <= '0;
      @(posedge clk_sys_i);
   endtask : pulse

   // Pulses crystal, oscillator, pin A or pin B n times, spaced apart.
   task automatic ticks(input int b, input int n);
      repeat (n) begin
         src_p[b] <= 1'b1;
         @(posedge clk_sys_i);
         src_p[b] <= 1'b0;
         repeat (3) @(posedge clk_sys_i);
      end
   endtask : ticks

   task automatic rst();
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask : rst

   // Runs a timer from 1000 for a fixed span, stops it and reads the count.
   task automatic span(input gtw_word_t b, input gtw_word_t c);
      logic e;
      wr(b, 32'd1000);
      wr(b + 8, c);
      repeat (64) @(posedge clk_sys_i);
      wr(b + 8, 32'h0);
      apb(1'b0, b + 4, '0, e);
   endtask : span

   initial begin
      rst();
      rd(`GTW_T2_COUNT_ADDR, 32'hFFFF_FFFF);
      rd(`GTW_T2_LOAD_ADDR, 32'h0);
      rd(`GTW_T2_CFG_ADDR, 32'h0);
      rd(`GTW_T1_CAP_ADDR, 32'h0);
      wr(`GTW_T2_COUNT_ADDR, 32'h1234);
      rd(`GTW_T2_COUNT_ADDR, 32'hFFFF_FFFF);
      rd(32'hFFFF_0400, 32'h0, 1'b1);
      $display("test registers done");
      core_run_i <= 1'b0;
      wr(`GTW_T2_LOAD_ADDR, 32'hA);
      wr(`GTW_T2_CFG_ADDR, 32'h80);
      ticks(0, 5);
      rd(`GTW_T2_COUNT_ADDR, 32'h5);
      wr(`GTW_T2_LOAD_ADDR, 32'h2);
      wr(`GTW_T2_CFG_ADDR, 32'h4C0);
      ticks(1, 3);
      rd(`GTW_T2_COUNT_ADDR, 32'h2);
      rd(`GTW_STATUS_ADDR, 32'h2);
      `CHK(t2_irq_o, 1'b1)
      wr(`GTW_T2_CLR_ADDR, 32'h0);
      `CHK(t2_irq_o, 1'b0)
      core_run_i <= 1'b1;
      $display("test wake-up done");
      wr(`GTW_T1_CFG_ADDR, 32'h0002_5000);
      wr(`GTW_T1_LOAD_ADDR, 32'h1234);
      pulse(5);
      rd(`GTW_T1_CAP_ADDR, 32'h0);
      pulse(7);
      rd(`GTW_T1_CAP_ADDR, 32'h1234);
      wr(`GTW_T1_CFG_ADDR, 32'h0000_5000);
      wr(`GTW_T1_LOAD_ADDR, 32'h55);
      pulse(7);
      rd(`GTW_T1_CAP_ADDR, 32'h1234);
      rd(`GTW_T1_COUNT_ADDR, 32'h55);
      $display("test capture done");
      wr(`GTW_T1_LOAD_ADDR, 32'h0100_0000);
      wr(`GTW_T1_CFG_ADDR, 32'h4A0);
      ticks(2, 1);
      rd(`GTW_T1_COUNT_ADDR, 32'h003B_3B63);
      wr(`GTW_T1_LOAD_ADDR, 32'h173B_3B63);
      wr(`GTW_T1_CFG_ADDR, 32'h7B0);
      ticks(3, 1);
      rd(`GTW_T1_COUNT_ADDR, 32'h1800_0000);
      wr(`GTW_T1_LOAD_ADDR, 32'h173B_3B63);
      wr(`GTW_T1_CFG_ADDR, 32'h7A0);
      ticks(3, 1);
      rd(`GTW_T1_COUNT_ADDR, 32'h0);
      wr(`GTW_T1_CFG_ADDR, 32'h0);
      $display("test format done");
      wr(`GTW_T1_LOAD_ADDR, 32'h2);
      wr(`GTW_T1_CFG_ADDR, 32'hC0);
      repeat (10) @(posedge clk_sys_i);
      `CHK(t1_irq_o, 1'b1)
      wr(`GTW_T1_CFG_ADDR, 32'h0);
      wr(`GTW_T1_CLR_ADDR, 32'h5A);
      repeat (2) @(posedge clk_sys_i);
      `CHK(t1_irq_o, 1'b0)
      wr(`GTW_T1_LOAD_ADDR, 32'h2);
      wr(`GTW_T1_CFG_ADDR, 32'h80);
      repeat (20) @(posedge clk_sys_i);
      `CHK(t1_irq_o, 1'b0)
      span(`GTW_T1_LOAD_ADDR, 32'h180);
      `CHK(q > 32'd1000, 1'b1)
      span(`GTW_T1_LOAD_ADDR, 32'h80);
      `CHK(q > 32'd920 && q < 32'd940, 1'b1)
      span(`GTW_T1_LOAD_ADDR, 32'h84);
      `CHK(q > 32'd990 && q < 32'd1000, 1'b1)
      span(`GTW_T1_LOAD_ADDR, 32'h88);
      `CHK(q, 32'd1000)
      span(`GTW_T3_LOAD_ADDR, 32'h8C);
      `CHK(q > 32'd920 && q < 32'd940, 1'b1)
      span(`GTW_T3_LOAD_ADDR, 32'h84);
      `CHK(q > 32'd990 && q < 32'd1000, 1'b1)
      $display("test counting done");
      rst();
      wr(`GTW_T3_LOAD_ADDR, 32'd30);
      wr(`GTW_T3_CFG_ADDR, 32'hA0);
      repeat (6) begin
         repeat (10) @(posedge clk_sys_i);
         wr(`GTW_T3_CLR_ADDR, 32'h77);
      end
      `CHK(wd_reset_o, 1'b0)
      repeat (40) @(posedge clk_sys_i);
      `CHK(wd_reset_o, 1'b1)
      rst();
      wr(`GTW_T3_LOAD_ADDR, 32'd20);
      wr(`GTW_T3_CFG_ADDR, 32'hA2);
      repeat (40) @(posedge clk_sys_i);
      `CHK(t3_irq_o, 1'b1)
      `CHK(wd_reset_o, 1'b0)
      $display("test watchdog done");
      rst();
      wr(`GTW_T3_LOAD_ADDR, 32'h1000);
      wr(`GTW_T3_CLR_ADDR, 32'hAA);
      wr(`GTW_T3_CFG_ADDR, 32'hB0);
      for (int i = 0; i < 4; i++) begin
         wr(`GTW_T3_CLR_ADDR, seq[i]);
         repeat (2) @(posedge clk_sys_i);
         `CHK(wd_reset_o, 1'b0)
      end
      wr(`GTW_T3_CLR_ADDR, 32'h66);
      repeat (2) @(posedge clk_sys_i);
      `CHK(wd_reset_o, 1'b1)
      rst();
      wr(`GTW_T3_LOAD_ADDR, 32'h1000);
      wr(`GTW_T3_CLR_ADDR, 32'h0);
      wr(`GTW_T3_CFG_ADDR, 32'hB0);
      wr(`GTW_T3_CLR_ADDR, 32'h0);
      repeat (2) @(posedge clk_sys_i);
      `CHK(wd_reset_o, 1'b1)
      $display("test secure clear done");
      complete_run();
   end
endmodule : tb_general_timers_with_watchdog
